/* File: startup_config_pkg.sv */
// constants for the start-up configuration sequencer: register offsets,
// field positions, per-mode defaults, state codes and slot timing.
// assumes a 40 MHz system clock and 16-bit control-interface registers.
package startup_config_pkg;

	localparam int NUM_SUPPLIES = 11;
	localparam int SLOT_W       = 4;
	localparam int VSEL_W       = 7;
	localparam int LIN_VSEL_W   = 5;
	localparam int DATA_W       = 16;
	localparam int ADDR_W       = 8;
	localparam int IDX_W        = 4;

	// supply index: 0..5 buck converters, 6 limit switch, 7..10 linear regulators
	localparam int IDX_LIMIT_SW  = 6;
	localparam int IDX_LIN_FIRST = 7;

	localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_RESET_DUR = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_NONE      = 8'h00;

	localparam logic [ADDR_W-1:0] SLOT_ADDR [NUM_SUPPLIES] = '{
		8'hB5, 8'hB7, 8'hBB, 8'hBE, 8'hC1, 8'hC4, 8'hC7, 8'hC9, 8'hCB, 8'hCF, 8'hD2};
	localparam logic [ADDR_W-1:0] VSEL_ADDR [NUM_SUPPLIES] = '{
		8'hB4, 8'h00, 8'hBA, 8'hBD, 8'h00, 8'hC3, 8'h00, 8'hC8, 8'hCA, 8'hCE, 8'hD1};

	// field positions of the start-up control register, and the low bit of the slot field in the slot registers
	localparam int CTRL_SEC_PORT_BIT = 15;
	localparam int CTRL_DEVADDR_HI   = 14;
	localparam int CTRL_DEVADDR_LO   = 13;
	localparam int CTRL_DONE_BIT     = 12;
	localparam int CTRL_RELOAD_BIT   = 11;
	localparam int SLOT_FIELD_LO     = 10;

	localparam logic [1:0] MODE_DEV = 2'h0;
	localparam logic [1:0] MODE_01  = 2'h1;
	localparam logic [1:0] MODE_10  = 2'h2;
	localparam logic [1:0] MODE_11  = 2'h3;

	// mode 01 supply table
	localparam logic [SLOT_W-1:0] M01_SLOT [NUM_SUPPLIES] = '{
		4'h4, 4'h0, 4'h1, 4'h1, 4'h0, 4'h4, 4'h0, 4'h3, 4'h2, 4'h1, 4'h2};
	localparam logic [VSEL_W-1:0] M01_VSEL [NUM_SUPPLIES] = '{
		7'h06, 7'h00, 7'h26, 7'h56, 7'h00, 7'h0A, 7'h00, 7'h02, 7'h1F, 7'h1C, 7'h04};

	// general defaults of the custom modes
	localparam logic       DEF_BUTTON_POL    = 1'h1;
	localparam logic       DEF_USB_LIMIT     = 1'h1;
	localparam logic [1:0] DEF_WDOG_M01      = 2'h0;
	localparam logic [1:0] DEF_WDOG_M10      = 2'h1;
	localparam logic       DEF_IFACE_SEL     = 1'h0;
	localparam logic       DEF_OSC_ENABLE    = 1'h1;
	localparam logic       DEF_TICK_ENABLE   = 1'h1;
	localparam logic       DEF_CLOCK_SOURCE  = 1'h0;
	localparam logic       DEF_LIN_PIN       = 1'h0;
	localparam logic       DEF_RELOAD        = 1'h1;

	localparam logic [SLOT_W-1:0] FIRST_SLOT = 4'h1;
	localparam logic [SLOT_W-1:0] LAST_SLOT  = 4'hF;
	localparam logic [SLOT_W-1:0] NO_SLOT    = 4'h0;

	localparam int  CLK_PERIOD_NS     = 25;
	localparam real SLOT_GAP_MS       = 1.28;
	localparam int  SLOT_GAP_CYCLES_D = $rtoi(SLOT_GAP_MS * 1.0e6 / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_LOAD     = 3'b001,
		ST_WAIT_CFG = 3'b010,
		ST_SEQUENCE = 3'b011,
		ST_ACTIVE   = 3'b100
	} state_t;

endpackage : startup_config_pkg

/* File: startup_config_sequencer.sv */
// start-up configuration sequencer: picks the start-up mode from two pins,
// loads mode defaults or waits for a development-mode host, then starts
// the supplies slot by slot.
// assumes the control-interface logic delivers one-cycle register strobes
// on clk, and that power on/off and reset-trigger requests are clk pulses.
//
// Overview of operation
// - mode from two pins, codes 00/01/10/11
// - custom modes refuse writes while off
// - mode 01 button polarity defaults to one
// - mode 01 USB slave limit selects 500mA
// - mode 01 watchdog field defaults to 00
// - mode 01 interface selects cleared, two-wire
// - mode 01 low-frequency oscillator enabled
// - mode 01 calendar tick on, source zero
// - mode 01 linear one pin controls cleared
// - start slots spaced about 1.28ms apart
// - mode 01 never closes limit switch
// - after reset-triggered setup, slot/duration writes ignored
// - done bit releases waiting device
// - writing zero to bit 15 selects primary port
// - slot zero means never started automatically
`timescale 1ns/1ps
`default_nettype none

module startup_config_sequencer
	import startup_config_pkg::*;
#(
	parameter int SLOT_GAP_CYCLES = startup_config_pkg::SLOT_GAP_CYCLES_D
) (
	input  wire logic                                       clk,
	input  wire logic                                       rstn,
	input  wire logic                                       mode_select_pin_high,
	input  wire logic                                       mode_select_pin_low,
	input  wire logic                                       power_on_req,
	input  wire logic                                       power_off_req,
	input  wire logic                                       config_reset_req,
	input  wire logic                                       reg_wr,
	input  wire logic                                       reg_rd,
	input  wire logic [startup_config_pkg::ADDR_W-1:0]      reg_addr,
	input  wire logic [startup_config_pkg::DATA_W-1:0]      reg_wdata,
	output logic      [startup_config_pkg::DATA_W-1:0]      reg_rdata,
	output logic      [startup_config_pkg::NUM_SUPPLIES-1:0] supply_enable,
	output logic      [startup_config_pkg::NUM_SUPPLIES-1:0][startup_config_pkg::VSEL_W-1:0]
	                                                        voltage_code,
	output logic      [1:0]                                 start_mode,
	output logic      [2:0]                                 seq_state,
	output logic                                            power_button_polarity,
	output logic                                            usb_slave_current_limit,
	output logic      [1:0]                                 watchdog_behaviour,
	output logic                                            three_wire_select,
	output logic                                            four_wire_select,
	output logic                                            serial_cfg_select,
	output logic                                            low_freq_osc_enable,
	output logic                                            calendar_tick_enable,
	output logic                                            calendar_clock_source,
	output logic                                            first_linear_pin_control,
	output logic                                            first_linear_pin_enable,
	output logic                                            secondary_port_select,
	output logic                                            reload_config_at_power_on,
	output logic      [1:0]                                 bus_device_address,
	output logic      [startup_config_pkg::DATA_W-1:0]      reset_pulse_duration
);
	import startup_config_pkg::*;

	localparam int GAP_W = $clog2(SLOT_GAP_CYCLES + 1);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(SLOT_GAP_CYCLES - 1);

	state_t                                     state_reg;
	logic [1:0]                                 pin_meta_reg;
	logic [1:0]                                 mode_sync_reg;
	logic [NUM_SUPPLIES-1:0][SLOT_W-1:0]        slot_reg;
	logic [SLOT_W-1:0]                          cur_slot_reg;
	logic [GAP_W-1:0]                           gap_cnt_reg;
	logic                                       done_reg;
	logic                                       rst_cfg_reg;
	logic [NUM_SUPPLIES-1:0]                    slot_match;
	logic [NUM_SUPPLIES-1:0]                    zero_mask;
	logic [NUM_SUPPLIES-1:0]                    ahead_mask;
	logic [IDX_W:0]                             slot_hit;
	logic [IDX_W:0]                             vsel_hit;
	logic                                       wr_ok;
	logic                                       custom_mode;

	// returns {hit, index} for an address found in a table
	function automatic logic [IDX_W:0] find_index(input logic [ADDR_W-1:0] addr,
	                                             input logic [ADDR_W-1:0] tbl [NUM_SUPPLIES]);
		logic [IDX_W:0] res;
		res = '0;
		for (int i = 0; i < NUM_SUPPLIES; i++) begin
			if (tbl[i] != ADDR_NONE && tbl[i] == addr) begin
				res = {1'b1, IDX_W'(i)};
			end
		end
		return res;
	endfunction : find_index

	assign slot_hit    = find_index(reg_addr, SLOT_ADDR);
	assign vsel_hit    = find_index(reg_addr, VSEL_ADDR);
	assign custom_mode = (state_reg == ST_OFF) ? (mode_sync_reg != MODE_DEV)
	                                           : (start_mode != MODE_DEV);
	// custom modes only take their built-in defaults while off
	assign wr_ok = reg_wr && !(custom_mode && state_reg == ST_OFF);

	always_comb begin
		for (int i = 0; i < NUM_SUPPLIES; i++) begin
			slot_match[i] = (slot_reg[i] == cur_slot_reg) && (slot_reg[i] != NO_SLOT);
			zero_mask[i]  = (slot_reg[i] == NO_SLOT);
			ahead_mask[i] = (slot_reg[i] > cur_slot_reg);
		end
	end

	// mode pins are asynchronous straps; sampled only through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta_reg  <= 2'h0;
			mode_sync_reg <= 2'h0;
		end else begin
			pin_meta_reg  <= {mode_select_pin_high, mode_select_pin_low};
			mode_sync_reg <= pin_meta_reg;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg    <= ST_OFF;
			start_mode   <= MODE_DEV;
			cur_slot_reg <= NO_SLOT;
			gap_cnt_reg  <= '0;
			rst_cfg_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					if (power_on_req) begin
						start_mode <= mode_sync_reg;
						state_reg  <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					rst_cfg_reg <= 1'b0;
					state_reg   <= (start_mode == MODE_DEV) ? ST_WAIT_CFG : ST_SEQUENCE;
					cur_slot_reg <= FIRST_SLOT;
					gap_cnt_reg  <= '0;
				end
				ST_WAIT_CFG: begin
					if (power_off_req) begin
						state_reg <= ST_OFF;
					end else if (done_reg) begin
						// after a reset-triggered setup the supplies already ran
						state_reg <= rst_cfg_reg ? ST_ACTIVE : ST_SEQUENCE;
					end
				end
				ST_SEQUENCE: begin
					if (power_off_req) begin
						state_reg <= ST_OFF;
					end else if (gap_cnt_reg == GAP_LAST) begin
						gap_cnt_reg <= '0;
						if (cur_slot_reg == LAST_SLOT) begin
							state_reg <= ST_ACTIVE;
						end else begin
							cur_slot_reg <= cur_slot_reg + 4'h1;
						end
					end else begin
						gap_cnt_reg <= gap_cnt_reg + GAP_W'(1);
					end
				end
				ST_ACTIVE: begin
					if (power_off_req) begin
						state_reg <= ST_OFF;
					end else if (config_reset_req && start_mode == MODE_DEV) begin
						rst_cfg_reg <= 1'b1;
						state_reg   <= ST_WAIT_CFG;
					end
				end
				default: state_reg <= ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seq_state <= 3'h0;
		end else begin
			seq_state <= state_reg;
		end
	end

	// supplies sharing a slot switch on in the same cycle; a reset-triggered
	// setup keeps the enables as they were, and host writes do not touch them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			supply_enable <= '0;
		end else if (state_reg == ST_OFF) begin
			supply_enable <= '0;
		end else if (state_reg == ST_SEQUENCE) begin
			supply_enable <= supply_enable | slot_match;
		end
	end

	// slot and voltage storage; custom modes overwrite it at load
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slot_reg     <= '0;
			voltage_code <= '0;
		end else if (state_reg == ST_LOAD && start_mode != MODE_DEV) begin
			for (int i = 0; i < NUM_SUPPLIES; i++) begin
				// mode 10/11 tables are not held: their supplies stay unslotted
				slot_reg[i]     <= (start_mode == MODE_01) ? M01_SLOT[i] : NO_SLOT;
				voltage_code[i] <= (start_mode == MODE_01) ? M01_VSEL[i] : 7'h00;
			end
			slot_reg[IDX_LIMIT_SW] <= NO_SLOT;
		end else if (state_reg == ST_OFF && power_off_req && reload_config_at_power_on) begin
			slot_reg     <= '0;
			voltage_code <= '0;
		end else if (wr_ok) begin
			if (slot_hit[IDX_W] && !rst_cfg_reg) begin
				slot_reg[slot_hit[IDX_W-1:0]] <= reg_wdata[SLOT_FIELD_LO +: SLOT_W];
			end
			if (vsel_hit[IDX_W]) begin
				if (vsel_hit[IDX_W-1:0] >= IDX_W'(IDX_LIN_FIRST)) begin
					voltage_code[vsel_hit[IDX_W-1:0]] <= {2'h0, reg_wdata[LIN_VSEL_W-1:0]};
				end else begin
					voltage_code[vsel_hit[IDX_W-1:0]] <= reg_wdata[VSEL_W-1:0];
				end
			end
		end
	end

	// start-up control register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			secondary_port_select     <= 1'b0;
			bus_device_address        <= 2'h0;
			done_reg                  <= 1'b0;
			reload_config_at_power_on <= DEF_RELOAD;
		end else if (state_reg == ST_LOAD) begin
			// development host talks over the secondary port until it lets go
			secondary_port_select     <= (start_mode == MODE_DEV);
			done_reg                  <= 1'b0;
			reload_config_at_power_on <= (start_mode == MODE_DEV) ? reload_config_at_power_on
			                                                      : DEF_RELOAD;
		end else if (wr_ok && reg_addr == ADDR_CONTROL) begin
			secondary_port_select     <= reg_wdata[CTRL_SEC_PORT_BIT];
			bus_device_address        <= reg_wdata[CTRL_DEVADDR_HI:CTRL_DEVADDR_LO];
			done_reg                  <= reg_wdata[CTRL_DONE_BIT];
			reload_config_at_power_on <= reg_wdata[CTRL_RELOAD_BIT];
		end else if (state_reg == ST_ACTIVE && config_reset_req) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_pulse_duration <= '0;
		end else if (wr_ok && reg_addr == ADDR_RESET_DUR && !rst_cfg_reg) begin
			reset_pulse_duration <= reg_wdata;
		end
	end

	// general custom-mode defaults
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_button_polarity    <= 1'b0;
			usb_slave_current_limit  <= 1'b0;
			watchdog_behaviour       <= 2'h0;
			three_wire_select        <= 1'b0;
			four_wire_select         <= 1'b0;
			serial_cfg_select        <= 1'b0;
			low_freq_osc_enable      <= 1'b0;
			calendar_tick_enable     <= 1'b0;
			calendar_clock_source    <= 1'b0;
			first_linear_pin_control <= 1'b0;
			first_linear_pin_enable  <= 1'b0;
		end else if (state_reg == ST_LOAD && start_mode != MODE_DEV) begin
			power_button_polarity    <= DEF_BUTTON_POL;
			usb_slave_current_limit  <= DEF_USB_LIMIT;
			watchdog_behaviour       <= (start_mode == MODE_10) ? DEF_WDOG_M10 : DEF_WDOG_M01;
			three_wire_select        <= DEF_IFACE_SEL;
			four_wire_select         <= DEF_IFACE_SEL;
			serial_cfg_select        <= DEF_IFACE_SEL;
			low_freq_osc_enable      <= DEF_OSC_ENABLE;
			calendar_tick_enable     <= DEF_TICK_ENABLE;
			calendar_clock_source    <= DEF_CLOCK_SOURCE;
			first_linear_pin_control <= DEF_LIN_PIN;
			first_linear_pin_enable  <= DEF_LIN_PIN;
		end
	end

	// read data: one cycle after the strobe, unmapped addresses read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_CONTROL) begin
				reg_rdata <= {secondary_port_select, bus_device_address, done_reg,
				              reload_config_at_power_on, 11'h000};
			end else if (reg_addr == ADDR_RESET_DUR) begin
				reg_rdata <= reset_pulse_duration;
			end else if (slot_hit[IDX_W]) begin
				reg_rdata <= {2'h0, slot_reg[slot_hit[IDX_W-1:0]], 10'h000};
			end else if (vsel_hit[IDX_W]) begin
				reg_rdata <= {9'h000, voltage_code[vsel_hit[IDX_W-1:0]]};
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_load_m01;
		state_reg == ST_LOAD && start_mode == MODE_01;
	endsequence
	sequence s_slot_step;
		state_reg == ST_SEQUENCE && $past(state_reg) == ST_SEQUENCE && $changed(cur_slot_reg);
	endsequence

	property p_mode_latch;
		state_reg == ST_OFF && power_on_req |=> start_mode == $past(mode_sync_reg);
	endproperty
	a_mode_latch: assert property (p_mode_latch) else $error("mode not taken from pins");

	property p_off_refuse;
		state_reg == ST_OFF && mode_sync_reg != MODE_DEV && reg_wr && !power_off_req
		|=> $stable(slot_reg) && $stable(voltage_code);
	endproperty
	a_off_refuse: assert property (p_off_refuse) else $error("write taken while off");

	property p_m01_power;
		s_load_m01 |=> power_button_polarity && usb_slave_current_limit
		               && watchdog_behaviour == 2'h0;
	endproperty
	a_m01_power: assert property (p_m01_power) else $error("mode 01 power defaults wrong");

	property p_m01_iface;
		s_load_m01 |=> !three_wire_select && !four_wire_select && !serial_cfg_select;
	endproperty
	a_m01_iface: assert property (p_m01_iface) else $error("mode 01 interface not two-wire");

	property p_m01_clock;
		s_load_m01 |=> low_freq_osc_enable && calendar_tick_enable && !calendar_clock_source
		               && !first_linear_pin_control && !first_linear_pin_enable;
	endproperty
	a_m01_clock: assert property (p_m01_clock) else $error("mode 01 clock defaults wrong");

	property p_slot_gap;
		s_slot_step |-> $past(gap_cnt_reg) == GAP_LAST && cur_slot_reg == $past(cur_slot_reg) + 4'h1;
	endproperty
	a_slot_gap: assert property (p_slot_gap) else $error("slot step off its spacing");

	property p_limit_open;
		state_reg == ST_ACTIVE && start_mode == MODE_01 |-> !supply_enable[IDX_LIMIT_SW];
	endproperty
	a_limit_open: assert property (p_limit_open) else $error("limit switch closed in mode 01");

	property p_rst_cfg_lock;
		rst_cfg_reg && reg_wr && (slot_hit[IDX_W] || reg_addr == ADDR_RESET_DUR)
		&& state_reg != ST_LOAD |=> $stable(slot_reg) && $stable(reset_pulse_duration);
	endproperty
	a_rst_cfg_lock: assert property (p_rst_cfg_lock) else $error("slot write after reset setup");

	property p_done_release;
		state_reg == ST_WAIT_CFG && done_reg && !power_off_req
		|=> state_reg == ($past(rst_cfg_reg) ? ST_ACTIVE : ST_SEQUENCE);
	endproperty
	a_done_release: assert property (p_done_release) else $error("done bit did not release");

	property p_primary_port;
		wr_ok && reg_addr == ADDR_CONTROL && !reg_wdata[CTRL_SEC_PORT_BIT] && state_reg != ST_LOAD
		|=> !secondary_port_select;
	endproperty
	a_primary_port: assert property (p_primary_port) else $error("port not returned to primary");

	property p_zero_slot;
		state_reg == ST_SEQUENCE && !rst_cfg_reg && $past(state_reg) != ST_ACTIVE
		|=> (supply_enable & $past(zero_mask)) == '0;
	endproperty
	a_zero_slot: assert property (p_zero_slot) else $error("unslotted supply started");

	property p_slot_order;
		state_reg == ST_SEQUENCE && $past(state_reg) != ST_ACTIVE
		|=> (supply_enable & $past(ahead_mask)) == '0 ##0
		    (supply_enable & $past(slot_match)) == $past(slot_match);
	endproperty
	a_slot_order: assert property (p_slot_order) else $error("supply started out of order");

endmodule : startup_config_sequencer

`default_nettype wire

/* File: config_host.sv */
// host model: a processor or programming device on the register strobes.
// assumes one clk shared with the device; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module config_host (
	input  wire logic        clk,
	input  wire logic [15:0] reg_rdata,
	output var logic         reg_wr,
	output var logic         reg_rd,
	output var logic [7:0]   reg_addr,
	output var logic [15:0]  reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// only start-up registers are written here; the rest waits for the running device
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// an idle bus must not keep showing the last value
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
	// done goes last, port handed back, reload bit kept at one
	task automatic finish_cfg();
		wr(8'h06, 16'h1800);
	endtask : finish_cfg
endmodule : config_host
`default_nettype wire

/* File: tb_top.sv */
// bench for the start-up sequencer with a short slot gap.
// assumes the host model drives all register strobes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import startup_config_pkg::*;
	logic clk, rstn, mode_select_pin_high, mode_select_pin_low, reg_wr, reg_rd;
	logic power_on_req, power_off_req, config_reset_req;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [10:0] supply_enable;
	logic [10:0][6:0] voltage_code;
	logic [1:0] start_mode, watchdog_behaviour;
	logic [2:0] seq_state;
	logic power_button_polarity, usb_slave_current_limit, three_wire_select, four_wire_select;
	logic serial_cfg_select, low_freq_osc_enable, calendar_tick_enable, calendar_clock_source;
	logic first_linear_pin_control, first_linear_pin_enable;
	logic secondary_port_select, reload_config_at_power_on;
	logic [1:0] bus_device_address;
	logic [15:0] reset_pulse_duration;
	int failures, tests_run, k, m;
	int slot01 [11] = '{4, 0, 1, 1, 0, 4, 0, 3, 2, 1, 2};
	logic [6:0] volt01 [11] = '{7'h06, 7'h00, 7'h26, 7'h56, 7'h00, 7'h0A, 7'h00, 7'h02, 7'h1F,
		7'h1C, 7'h04};
	// a short gap keeps the run small; expectations use the same figure
	localparam int GAP = 8;
	startup_config_sequencer #(.SLOT_GAP_CYCLES(GAP)) startup_config_sequencer_i (.*);
	config_host config_host_i (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [10:0] upto(int s);
		upto = '0;
		for (int i = 0; i < 11; i++) if (slot01[i] != 0 && slot01[i] <= s) upto[i] = 1'b1;
	endfunction : upto
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wait_st(logic [2:0] s);
		for (int i = 0; i < 400 && seq_state !== s; i++) @(posedge clk) #1;
		if (seq_state !== s) begin
			chk("seq_state", s, seq_state);
			end_sim();
		end
	endtask : wait_st
	task automatic wait_sup();
		for (int i = 0; i < 100 && supply_enable === '0; i++) @(posedge clk) #1;
		if (supply_enable === '0) begin
			chk("supply_enable", 16'h1, supply_enable);
			end_sim();
		end
	endtask : wait_sup
	// 0 power on, 1 power off, 2 reset-triggered setup
	task automatic pulse(int w);
		@(posedge clk);
		case (w)
			0: power_on_req <= 1'b1;
			1: power_off_req <= 1'b1;
			default: config_reset_req <= 1'b1;
		endcase
		@(posedge clk);
		{power_on_req, power_off_req, config_reset_req} <= 3'h0;
	endtask : pulse
	task automatic straps(logic [1:0] c);
		@(posedge clk);
		{mode_select_pin_high, mode_select_pin_low} <= c;
		repeat (3) @(posedge clk);
	endtask : straps
	initial begin
		{rstn, power_on_req, power_off_req, config_reset_req} = 4'h0;
		{mode_select_pin_high, mode_select_pin_low} = 2'b01;
		failures = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("reload", 1, reload_config_at_power_on);
		config_host_i.wr(8'hB7, 16'h0800);
		config_host_i.rd(8'hB7, d);
		chk("off write", 0, d);
		pulse(0);
		wait_st(3'h3);
		chk("mode", 1, start_mode);
		chk("polarity", 1, power_button_polarity);
		chk("usb", 1, usb_slave_current_limit);
		chk("watchdog", 0, watchdog_behaviour);
		chk("iface", 0, {three_wire_select, four_wire_select, serial_cfg_select});
		chk("osc", 1, low_freq_osc_enable);
		chk("clock", 2, {calendar_tick_enable, calendar_clock_source});
		chk("lin pin", 0, {first_linear_pin_control, first_linear_pin_enable});
		for (k = 0; k < 11; k++) chk("voltage", volt01[k], voltage_code[k]);
		wait_sup();
		repeat (GAP / 2) @(posedge clk);
		for (k = 1; k <= 4; k++) begin
			chk("slot mask", upto(k), supply_enable);
			repeat (GAP) @(posedge clk);
		end
		wait_st(3'h4);
		chk("limit switch", 0, supply_enable[IDX_LIMIT_SW]);
		$display("mode 01 start-up done");
		for (m = 2; m <= 3; m++) begin
			pulse(1);
			straps(m[1:0]);
			pulse(0);
			wait_st(3'h3);
			chk("mode", m, start_mode);
			chk("watchdog", m == 2, watchdog_behaviour);
		end
		$display("modes 10 and 11 done");
		pulse(1);
		straps(2'b00);
		pulse(0);
		wait_st(3'h2);
		config_host_i.wr(8'hB7, 16'h0400);
		config_host_i.wr(8'hD2, 16'h0800);
		config_host_i.wr(8'hBA, 16'h0055);
		config_host_i.wr(8'hC7, 16'h0000);
		config_host_i.wr(8'h03, 16'h1234);
		config_host_i.rd(8'hB7, d);
		chk("slot read", 16'h0400, d);
		config_host_i.rd(8'h01, d);
		chk("unmapped", 0, d);
		chk("held", 0, supply_enable);
		config_host_i.finish_cfg();
		wait_st(3'h3);
		chk("port", 0, secondary_port_select);
		chk("device address", 0, bus_device_address);
		chk("reset duration", 16'h1234, reset_pulse_duration);
		chk("reload", 1, reload_config_at_power_on);
		wait_sup();
		chk("first slot", 11'h002, supply_enable);
		wait_st(3'h4);
		chk("dev mask", 11'h402, supply_enable);
		chk("voltage", 7'h55, voltage_code[2]);
		$display("development mode done");
		pulse(2);
		repeat (2) @(posedge clk);
		config_host_i.wr(8'hB7, 16'h2000);
		config_host_i.wr(8'h03, 16'h5678);
		chk("duration after reset", 16'h1234, reset_pulse_duration);
		config_host_i.rd(8'hB7, d);
		chk("slot after reset", 16'h0400, d);
		config_host_i.finish_cfg();
		wait_st(3'h4);
		chk("supplies kept", 11'h402, supply_enable);
		$display("reset-triggered setup done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
